/* usb_otg_line_power_defs.svh */
// Offsets, bit positions, reset values and timing figures of the USB line/power control block.
// Assumes a 100 MHz system clock and word-aligned byte addresses on the register port.
`ifndef USB_OTG_LINE_POWER_DEFS_SVH
`define USB_OTG_LINE_POWER_DEFS_SVH

// Register byte addresses
`define OFS_OTG_LINE_CONTROL 8'h00
`define OFS_USB_POWER_CONTROL 8'h04
`define OFS_USB_INTERRUPT_FLAGS 8'h08

// Line control bits
`define BIT_DPLUS_PULL_UP 7
`define BIT_DMINUS_PULL_UP 6
`define BIT_DPLUS_PULL_DOWN 5
`define BIT_DMINUS_PULL_DOWN 4
`define BIT_VBUS_POWER_ON 3
`define BIT_SW_PULL_CONTROL 2
`define BIT_VBUS_CHARGE 1
`define BIT_VBUS_DISCHARGE 0

// Power control bits
`define BIT_ACTIVITY_PENDING 7
`define BIT_SLEEP_GUARD 4
`define BIT_MODULE_BUSY 3
`define BIT_SUSPEND 1
`define BIT_MODULE_POWER 0

// Interrupt flag bits
`define BIT_STALL_FLAG 7
`define BIT_ATTACH_FLAG 6
`define BIT_RESUME_FLAG 5
`define BIT_IDLE_FLAG 4
`define BIT_TOKEN_DONE_FLAG 3
`define BIT_FRAME_START_FLAG 2
`define BIT_ERROR_FLAG 1
`define BIT_RESET_DETACH_FLAG 0

// Reset values
`define RST_LINE_CONTROL 8'h00
`define RST_POWER_CONTROL 8'h00
`define RST_INTERRUPT_FLAGS 8'h00

// Timing
`define CLK_PERIOD_NS 10
`define RESUME_K_TIME_NS 2500
`define IDLE_TIME_US 3000
`define SHUTDOWN_CYCLES 16

`endif

/* usb_otg_line_power_pkg.sv */
// Types shared by the USB line/power control block.
// Assumes the matching _defs header supplies all numeric constants.
package usb_otg_line_power_pkg;

  typedef struct packed {
    logic dplus_pull_up_en;
    logic dminus_pull_up_en;
    logic dplus_pull_down_en;
    logic dminus_pull_down_en;
  } pull_t;

  typedef struct packed {
    logic dplus;
    logic dminus;
  } line_t;

  typedef enum logic [1:0] {
    PWR_OFF,
    PWR_ON,
    PWR_SETTLE
  } power_state_t;

endpackage

/* line_hold_detect.sv */
// Pulses once when a condition has held for a given number of clock cycles.
// Assumes the condition is already in the clock domain.
`timescale 1ns/1ps
module line_hold_detect #(
  parameter int CYCLES = 250
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cond_i,
  output logic hit_o
);

  localparam int W = $clog2(CYCLES + 1);

  if (CYCLES < 1) begin : g_check
    $error("line_hold_detect needs CYCLES of at least one");
  end

  logic [W-1:0] count;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= '0;
      hit_o <= 1'b0;
    end else if (ce_i) begin
      hit_o <= 1'b0;
      if (!cond_i) begin
        count <= '0;
      end else if (count != W'(CYCLES)) begin
        count <= count + W'(1);
        // Fire exactly once, on the cycle the hold time is reached
        hit_o <= (count == W'(CYCLES - 1));
      end
    end
  end

endmodule

/* usb_otg_line_power_ctrl.sv */
// USB OTG line, VBUS and module power control with the interrupt flag register.
// Assumes register strobes and core events are on CLK_I; D+ and D- arrive from the cable asynchronously.
//
// Operation
// - Bits 31 to 8 of every register read as zero.
// - D+ pull-up bit one enables D+ pull-up, zero disables it.
// - Bit 6 enables the D- pull-up when one, disables when zero.
// - Bit 5 enables the D+ pull-down when one, disables when zero.
// - Bit 4 enables the D- pull-down when one, disables when zero.
// - Bit 3 one powers VBUS; zero leaves VBUS unsupplied.
// - Bit 2 one gives software the pull bits, zero gives hardware control.
// - Bit 1 one charges VBUS through a pull-up; zero applies no charge.
// - Bit 0 one discharges VBUS through a pull-down; zero applies none.
// - Bit 7 reads one while activity seen but its interrupt not raised.
// - Guard bit set blocks sleep on activity or pending notification.
// - Busy reads one while active or not yet ready to re-enable.
// - Suspend gates the 48 MHz USB clock and idles the transceiver.
// - Power bit zero holds outputs inactive, frees pins, stops analog.
// - Hardware sets flags, reset clears them, writing one clears; the error flag (bit 1) reads ERROR_PENDING_I directly.
// - Clearing the token-done flag advances the status FIFO.
// - Resume flag sets after a K-state for 2.5 us.
// - Idle flag sets after 3 ms of continuous idle bus.
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "usb_otg_line_power_defs.svh"
module usb_otg_line_power_ctrl #(
  parameter int IDLE_CYCLES = `IDLE_TIME_US * 1000 / `CLK_PERIOD_NS,
  parameter int SHUTDOWN_CYCLES = `SHUTDOWN_CYCLES
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CE_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  input wire logic DPLUS_I,
  input wire logic DMINUS_I,
  input wire logic HOST_MODE_I,
  input wire logic STALL_EVT_I,
  input wire logic ATTACH_EVT_I,
  input wire logic TOKEN_DONE_EVT_I,
  input wire logic FRAME_START_EVT_I,
  input wire logic ERROR_PENDING_I,
  input wire logic RESET_DETACH_EVT_I,
  input wire logic SLEEP_REQ_I,
  output logic SLEEP_BLOCK_O,
  output usb_otg_line_power_pkg::pull_t PULL_O,
  output logic VBUS_POWER_O,
  output logic VBUS_CHARGE_O,
  output logic VBUS_DISCHARGE_O,
  output logic USB_CLK_EN_O,
  output logic XCVR_LOW_POWER_O,
  output logic PINS_OWNED_O,
  output logic ANALOG_EN_O,
  output logic STAT_FIFO_ADVANCE_O
);

  localparam int RESUME_CYCLES = (`RESUME_K_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int SW = $clog2(SHUTDOWN_CYCLES + 1);

  if (IDLE_CYCLES < 1 || SHUTDOWN_CYCLES < 1) begin : g_check
    $error("usb_otg_line_power_ctrl needs positive cycle counts");
  end

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] line_control;
  logic sleep_entry_guard;
  logic suspend_request;
  logic module_power_on;
  logic [7:0] flags;
  logic activity_irq_pending;
  logic module_busy;
  usb_otg_line_power_pkg::power_state_t power_state;
  logic [SW-1:0] settle_count;

  logic wr_line;
  logic wr_power;
  logic wr_flags;
  logic [7:0] clear_mask;

  assign wr_line = WR_I && reg_hit(ADDR_I, `OFS_OTG_LINE_CONTROL);
  assign wr_power = WR_I && reg_hit(ADDR_I, `OFS_USB_POWER_CONTROL);
  assign wr_flags = WR_I && reg_hit(ADDR_I, `OFS_USB_INTERRUPT_FLAGS);
  assign clear_mask = wr_flags ? WDATA_I[7:0] : 8'h00;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      line_control <= `RST_LINE_CONTROL;
    end else if (CE_I && wr_line) begin
      line_control <= WDATA_I[7:0];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      sleep_entry_guard <= 1'(`RST_POWER_CONTROL >> `BIT_SLEEP_GUARD);
      suspend_request <= 1'(`RST_POWER_CONTROL >> `BIT_SUSPEND);
      module_power_on <= 1'(`RST_POWER_CONTROL >> `BIT_MODULE_POWER);
    end else if (CE_I && wr_power) begin
      sleep_entry_guard <= WDATA_I[`BIT_SLEEP_GUARD];
      suspend_request <= WDATA_I[`BIT_SUSPEND];
      module_power_on <= WDATA_I[`BIT_MODULE_POWER];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Module power sequencing and busy indication

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      power_state <= usb_otg_line_power_pkg::PWR_OFF;
      settle_count <= '0;
    end else if (CE_I) begin
      case (power_state)
        usb_otg_line_power_pkg::PWR_OFF: begin
          if (module_power_on) begin
            power_state <= usb_otg_line_power_pkg::PWR_ON;
          end
        end
        usb_otg_line_power_pkg::PWR_ON: begin
          // Shutdown takes a while before the module may be re-enabled
          if (!module_power_on) begin
            power_state <= usb_otg_line_power_pkg::PWR_SETTLE;
            settle_count <= SW'(SHUTDOWN_CYCLES);
          end
        end
        usb_otg_line_power_pkg::PWR_SETTLE: begin
          if (settle_count == SW'(1)) begin
            power_state <= usb_otg_line_power_pkg::PWR_OFF;
          end
          settle_count <= settle_count - SW'(1);
        end
        default: begin
          power_state <= usb_otg_line_power_pkg::PWR_OFF;
        end
      endcase
    end
  end

  assign module_busy = (power_state != usb_otg_line_power_pkg::PWR_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // Line input synchronisation, three stages with agreement filter

  usb_otg_line_power_pkg::line_t line_s1;
  usb_otg_line_power_pkg::line_t line_s2;
  usb_otg_line_power_pkg::line_t line_s3;
  usb_otg_line_power_pkg::line_t line;
  logic line_changed;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      line_s1 <= '0;
      line_s2 <= '0;
      line_s3 <= '0;
      line <= '0;
      line_changed <= 1'b0;
    end else if (CE_I) begin
      line_s1 <= {DPLUS_I, DMINUS_I};
      line_s2 <= line_s1;
      line_s3 <= line_s2;
      line_changed <= 1'b0;
      if (line_s2 == line_s3) begin
        line <= line_s3;
        line_changed <= (line != line_s3);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Resume and idle detection

  logic k_state;
  logic j_state;
  logic resume_hit;
  logic idle_hit;

  assign k_state = !line.dplus && line.dminus;
  assign j_state = line.dplus && !line.dminus;

  line_hold_detect #(
    .CYCLES(RESUME_CYCLES)
  ) u_resume_detect (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .ce_i(CE_I),
    .cond_i(module_power_on && k_state),
    .hit_o(resume_hit)
  );

  line_hold_detect #(
    .CYCLES(IDLE_CYCLES)
  ) u_idle_detect (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .ce_i(CE_I),
    .cond_i(module_power_on && j_state),
    .hit_o(idle_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags: set wins over a simultaneous write-one clear

  logic [7:0] set_mask;

  always_comb begin
    set_mask = 8'h00;
    if (module_power_on) begin
      set_mask[`BIT_STALL_FLAG] = STALL_EVT_I;
      set_mask[`BIT_ATTACH_FLAG] = ATTACH_EVT_I;
      set_mask[`BIT_RESUME_FLAG] = resume_hit;
      set_mask[`BIT_IDLE_FLAG] = idle_hit;
      set_mask[`BIT_TOKEN_DONE_FLAG] = TOKEN_DONE_EVT_I;
      set_mask[`BIT_FRAME_START_FLAG] = FRAME_START_EVT_I;
      set_mask[`BIT_RESET_DETACH_FLAG] = RESET_DETACH_EVT_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      flags <= `RST_INTERRUPT_FLAGS;
    end else if (CE_I) begin
      flags <= (flags & ~clear_mask) | set_mask;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      STAT_FIFO_ADVANCE_O <= 1'b0;
    end else if (CE_I) begin
      STAT_FIFO_ADVANCE_O <= clear_mask[`BIT_TOKEN_DONE_FLAG] && flags[`BIT_TOKEN_DONE_FLAG];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Activity pending and sleep guard

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      activity_irq_pending <= 1'b0;
    end else if (CE_I) begin
      // Pending from activity in suspend until the resume flag is raised
      if (resume_hit || !suspend_request || !module_power_on) begin
        activity_irq_pending <= 1'b0;
      end else if (line_changed) begin
        activity_irq_pending <= 1'b1;
      end
    end
  end

  assign SLEEP_BLOCK_O = sleep_entry_guard && SLEEP_REQ_I && (line_changed || activity_irq_pending);

  ////////////////////////////////////////////////////////////////////////////
  // Line and power outputs

  usb_otg_line_power_pkg::pull_t sw_pull;
  usb_otg_line_power_pkg::pull_t hw_pull;
  usb_otg_line_power_pkg::pull_t next_pull;

  always_comb begin
    sw_pull.dplus_pull_up_en = line_control[`BIT_DPLUS_PULL_UP];
    sw_pull.dminus_pull_up_en = line_control[`BIT_DMINUS_PULL_UP];
    sw_pull.dplus_pull_down_en = line_control[`BIT_DPLUS_PULL_DOWN];
    sw_pull.dminus_pull_down_en = line_control[`BIT_DMINUS_PULL_DOWN];
    hw_pull.dplus_pull_up_en = !HOST_MODE_I;
    hw_pull.dminus_pull_up_en = 1'b0;
    hw_pull.dplus_pull_down_en = HOST_MODE_I;
    hw_pull.dminus_pull_down_en = HOST_MODE_I;
    next_pull = line_control[`BIT_SW_PULL_CONTROL] ? sw_pull : hw_pull;
    if (!module_power_on) begin
      next_pull = '0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      PULL_O <= '0;
      VBUS_POWER_O <= 1'b0;
      VBUS_CHARGE_O <= 1'b0;
      VBUS_DISCHARGE_O <= 1'b0;
    end else if (CE_I) begin
      PULL_O <= next_pull;
      VBUS_POWER_O <= module_power_on && line_control[`BIT_VBUS_POWER_ON];
      VBUS_CHARGE_O <= module_power_on && line_control[`BIT_VBUS_CHARGE];
      VBUS_DISCHARGE_O <= module_power_on && line_control[`BIT_VBUS_DISCHARGE];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      USB_CLK_EN_O <= 1'b0;
      XCVR_LOW_POWER_O <= 1'b1;
      PINS_OWNED_O <= 1'b0;
      ANALOG_EN_O <= 1'b0;
    end else if (CE_I) begin
      USB_CLK_EN_O <= module_power_on && !suspend_request;
      XCVR_LOW_POWER_O <= !module_power_on || suspend_request;
      PINS_OWNED_O <= module_power_on;
      ANALOG_EN_O <= module_power_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port, data valid the cycle after the strobe

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      RDATA_O <= 32'h0000_0000;
    end else if (CE_I) begin
      RDATA_O <= 32'h0000_0000;
      if (RD_I) begin
        case (ADDR_I)
          `OFS_OTG_LINE_CONTROL: begin
            RDATA_O[7:0] <= line_control;
          end
          `OFS_USB_POWER_CONTROL: begin
            RDATA_O[`BIT_ACTIVITY_PENDING] <= activity_irq_pending;
            RDATA_O[`BIT_SLEEP_GUARD] <= sleep_entry_guard;
            RDATA_O[`BIT_MODULE_BUSY] <= module_busy;
            RDATA_O[`BIT_SUSPEND] <= suspend_request;
            RDATA_O[`BIT_MODULE_POWER] <= module_power_on;
          end
          `OFS_USB_INTERRUPT_FLAGS: begin
            RDATA_O[7:0] <= flags;
            RDATA_O[`BIT_ERROR_FLAG] <= ERROR_PENDING_I;
          end
          default: begin
            RDATA_O <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

endmodule

/* usb_otg_line_power_ctrl_assertions.sv */
// Concurrent checks on the ports of the USB line/power control block.
// Assumes CE_I is high while the module is powered and HOST_MODE_I is steady around control writes.
`timescale 1ns/1ps
`include "usb_otg_line_power_defs.svh"
module usb_otg_line_power_ctrl_checker #(
  parameter int IDLE_CYCLES = 300000,
  parameter int SHUTDOWN_CYCLES = 16
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [31:0] RDATA_O,
  input wire logic HOST_MODE_I,
  input wire logic STALL_EVT_I,
  input wire logic SLEEP_REQ_I,
  input wire logic SLEEP_BLOCK_O,
  input wire usb_otg_line_power_pkg::pull_t PULL_O,
  input wire logic VBUS_POWER_O,
  input wire logic VBUS_CHARGE_O,
  input wire logic VBUS_DISCHARGE_O,
  input wire logic USB_CLK_EN_O,
  input wire logic XCVR_LOW_POWER_O,
  input wire logic PINS_OWNED_O,
  input wire logic ANALOG_EN_O,
  input wire logic STAT_FIFO_ADVANCE_O
);
  default clocking @(posedge CLK_I);
  endclocking
  default disable iff (SYS_RST_I);

  a_upper_read_zero: assert property (RDATA_O[31:8] == 24'h00_0000)
    else $error("upper read data bits set");
  a_pull_select: assert property (
    WR_I && ADDR_I == `OFS_OTG_LINE_CONTROL && PINS_OWNED_O |-> ##2
    PULL_O == ($past(WDATA_I[2], 2) ? $past(WDATA_I[7:4], 2) : (HOST_MODE_I ? 4'h3 : 4'h8)))
    else $error("pull enables differ from control");
  a_vbus_map: assert property (
    WR_I && ADDR_I == `OFS_OTG_LINE_CONTROL && PINS_OWNED_O |-> ##2
    {VBUS_POWER_O, VBUS_CHARGE_O, VBUS_DISCHARGE_O} == {$past(WDATA_I[3], 2), $past(WDATA_I[1:0], 2)})
    else $error("vbus controls differ from control");
  a_power_follow: assert property (
    WR_I && ADDR_I == `OFS_USB_POWER_CONTROL |-> ##2 PINS_OWNED_O == $past(WDATA_I[0], 2)
    && USB_CLK_EN_O == ($past(WDATA_I[0], 2) && !$past(WDATA_I[1], 2)))
    else $error("power or clock gate wrong after write");
  a_off_quiet: assert property (
    !PINS_OWNED_O |-> {PULL_O, VBUS_POWER_O, VBUS_CHARGE_O, VBUS_DISCHARGE_O, USB_CLK_EN_O, ANALOG_EN_O,
    XCVR_LOW_POWER_O} == 10'h001)
    else $error("outputs active while powered off");
  a_sleep_cause: assert property (SLEEP_BLOCK_O |-> SLEEP_REQ_I)
    else $error("sleep blocked without request");
  a_fifo_pulse: assert property (
    STAT_FIFO_ADVANCE_O |-> $past(WR_I && ADDR_I == `OFS_USB_INTERRUPT_FLAGS && WDATA_I[3]) ##1 !STAT_FIFO_ADVANCE_O)
    else $error("fifo advance without token clear");
  a_flag_sets: assert property (
    STALL_EVT_I && PINS_OWNED_O && !WR_I ##1 RD_I && ADDR_I == `OFS_USB_INTERRUPT_FLAGS |=> RDATA_O[7])
    else $error("stall flag not set by event");
endmodule

bind usb_otg_line_power_ctrl usb_otg_line_power_ctrl_checker #(.IDLE_CYCLES(IDLE_CYCLES),
  .SHUTDOWN_CYCLES(SHUTDOWN_CYCLES)) chk_i (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .HOST_MODE_I(HOST_MODE_I),
  .STALL_EVT_I(STALL_EVT_I), .SLEEP_REQ_I(SLEEP_REQ_I), .SLEEP_BLOCK_O(SLEEP_BLOCK_O), .PULL_O(PULL_O),
  .VBUS_POWER_O(VBUS_POWER_O), .VBUS_CHARGE_O(VBUS_CHARGE_O), .VBUS_DISCHARGE_O(VBUS_DISCHARGE_O),
  .USB_CLK_EN_O(USB_CLK_EN_O), .XCVR_LOW_POWER_O(XCVR_LOW_POWER_O), .PINS_OWNED_O(PINS_OWNED_O),
  .ANALOG_EN_O(ANALOG_EN_O), .STAT_FIFO_ADVANCE_O(STAT_FIFO_ADVANCE_O));

/* usb_cable_partner.sv */
// Cable-side model: the D+ and D- levels that the far end puts on the wire.
// Assumes a full-speed link; when detached the lines follow the block's own pull-ups.
`timescale 1ns/1ps
module usb_cable_partner (
  input wire logic [1:0] state_i,
  input wire usb_otg_line_power_pkg::pull_t pull_i,
  output logic dplus_o,
  output logic dminus_o
);
  // State 0 idle J, 1 resume K, 2 single-ended zero, 3 detached
  always_comb begin
    case (state_i)
      2'h0: {dplus_o, dminus_o} = 2'h2;
      2'h1: {dplus_o, dminus_o} = 2'h1;
      2'h2: {dplus_o, dminus_o} = 2'h0;
      default: {dplus_o, dminus_o} = {pull_i.dplus_pull_up_en, pull_i.dminus_pull_up_en};
    endcase
  end
endmodule

/* usb_otg_line_power_ctrl_bench.sv */
// Self-checking bench for the USB line/power control block.
// Assumes the checker binds itself; every task except chk starts and ends in a rising-edge time step.
`timescale 1ns/1ps
`include "usb_otg_line_power_defs.svh"
module usb_otg_line_power_ctrl_bench;
  localparam int IDLE_N = 50;
  localparam int OFF_N = 4;
  logic clk = 0, rst = 1, wr = 0, rd = 0, host = 0, err = 0, slp = 0, ce = 1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [4:0] evt = 5'h00;
  logic [1:0] line = 2'h0;
  logic [31:0] rdata;
  logic dp, dm, blk, fifo, vpow, vchg, vdis, uclk, xlp, pins, ana;
  usb_otg_line_power_pkg::pull_t pull;
  wire [10:0] outv = {pull, vpow, vchg, vdis, uclk, xlp, pins, ana};
  int num_errors = 0, cmp_count = 0, cycles = 0;

  usb_otg_line_power_ctrl #(.IDLE_CYCLES(IDLE_N), .SHUTDOWN_CYCLES(OFF_N)) dut (
    .CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .DPLUS_I(dp), .DMINUS_I(dm), .HOST_MODE_I(host), .STALL_EVT_I(evt[4]),
    .ATTACH_EVT_I(evt[3]), .TOKEN_DONE_EVT_I(evt[2]), .FRAME_START_EVT_I(evt[1]), .ERROR_PENDING_I(err),
    .RESET_DETACH_EVT_I(evt[0]), .SLEEP_REQ_I(slp), .SLEEP_BLOCK_O(blk), .PULL_O(pull), .VBUS_POWER_O(vpow),
    .VBUS_CHARGE_O(vchg), .VBUS_DISCHARGE_O(vdis), .USB_CLK_EN_O(uclk), .XCVR_LOW_POWER_O(xlp),
    .PINS_OWNED_O(pins), .ANALOG_EN_O(ana), .STAT_FIFO_ADVANCE_O(fifo));
  usb_cable_partner cable (.state_i(line), .pull_i(pull), .dplus_o(dp), .dminus_o(dm));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    chk($sformatf("register %h", a), {24'h00_0000, exp}, rdata);
    @(posedge clk);
  endtask
  task automatic outs(input logic [10:0] exp);
    @(posedge clk);
    #1;
    chk("outputs", {21'h0, exp}, {21'h0, outv});
    @(posedge clk);
  endtask
  task automatic pulse(input logic [4:0] v);
    evt <= v;
    @(posedge clk);
    evt <= 5'h00;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    outs(11'h004);
    rd_reg(`OFS_OTG_LINE_CONTROL, 8'h00);
    rd_reg(`OFS_USB_POWER_CONTROL, 8'h00);
    rd_reg(`OFS_USB_INTERRUPT_FLAGS, 8'h00);
    rd_reg(8'h0C, 8'h00);
    wr_reg(`OFS_OTG_LINE_CONTROL, 32'h0000_00FF);
    outs(11'h004);
    wr_reg(`OFS_OTG_LINE_CONTROL, 32'h0000_0000);
    @(posedge clk);
    $display("test reset done");
  endtask
  task automatic t_power_on();
    // Single-ended zero keeps the idle detector quiet until the idle test
    line <= 2'h2;
    wr_reg(`OFS_USB_POWER_CONTROL, 32'hFFFF_FF01);
    outs(11'h40B);
    rd_reg(`OFS_USB_POWER_CONTROL, 8'h09);
    $display("test power on done");
  endtask
  task automatic t_line();
    logic [7:0] v;
    for (int b = 0; b < 8; b++) begin
      if (b != 2) begin
        v = 8'h04 | (8'h01 << b);
        wr_reg(`OFS_OTG_LINE_CONTROL, 32'hFFFF_FF00 | {24'h00_0000, v});
        outs({v[7:4], v[3], v[1:0], 4'hB});
        rd_reg(`OFS_OTG_LINE_CONTROL, v);
      end
    end
    host <= 1'h1;
    wr_reg(`OFS_OTG_LINE_CONTROL, 32'h0000_0000);
    outs(11'h18B);
    host <= 1'h0;
    wr_reg(`OFS_OTG_LINE_CONTROL, 32'h0000_0000);
    outs(11'h40B);
    $display("test line control done");
  endtask
  task automatic t_flags();
    wr_reg(`OFS_USB_INTERRUPT_FLAGS, 32'h0000_00FF);
    err <= 1'h1;
    pulse(5'h1F);
    rd_reg(`OFS_USB_INTERRUPT_FLAGS, 8'hCF);
    wr_reg(`OFS_USB_INTERRUPT_FLAGS, 32'h0000_0000);
    rd_reg(`OFS_USB_INTERRUPT_FLAGS, 8'hCF);
    wr_reg(`OFS_USB_INTERRUPT_FLAGS, 32'h0000_0008);
    #1;
    chk("fifo advance", 32'h1, {31'h0, fifo});
    @(posedge clk);
    #1;
    chk("fifo advance", 32'h0, {31'h0, fifo});
    @(posedge clk);
    rd_reg(`OFS_USB_INTERRUPT_FLAGS, 8'hC7);
    wr_reg(`OFS_USB_INTERRUPT_FLAGS, 32'h0000_0008);
    #1;
    chk("fifo advance", 32'h0, {31'h0, fifo});
    @(posedge clk);
    wr_reg(`OFS_USB_INTERRUPT_FLAGS, 32'h0000_00FF);
    rd_reg(`OFS_USB_INTERRUPT_FLAGS, 8'h02);
    err <= 1'h0;
    pulse(5'h10);
    rd_reg(`OFS_USB_INTERRUPT_FLAGS, 8'h80);
    $display("test flags done");
  endtask
  task automatic t_suspend();
    slp <= 1'h1;
    wr_reg(`OFS_USB_POWER_CONTROL, 32'h0000_0013);
    outs(11'h407);
    wr_reg(`OFS_USB_INTERRUPT_FLAGS, 32'h0000_00FF);
    line <= 2'h1;
    repeat (12) @(posedge clk);
    #1;
    chk("sleep block", 32'h1, {31'h0, blk});
    @(posedge clk);
    rd_reg(`OFS_USB_POWER_CONTROL, 8'h9B);
    repeat (280) @(posedge clk);
    rd_reg(`OFS_USB_POWER_CONTROL, 8'h1B);
    rd_reg(`OFS_USB_INTERRUPT_FLAGS, 8'h20);
    line <= 2'h0;
    wr_reg(`OFS_USB_POWER_CONTROL, 32'h0000_0001);
    @(posedge clk);
    wr_reg(`OFS_USB_INTERRUPT_FLAGS, 32'h0000_00FF);
    repeat (IDLE_N - 20) @(posedge clk);
    rd_reg(`OFS_USB_INTERRUPT_FLAGS, 8'h00);
    #1;
    chk("sleep block", 32'h0, {31'h0, blk});
    repeat (40) @(posedge clk);
    rd_reg(`OFS_USB_INTERRUPT_FLAGS, 8'h10);
    slp <= 1'h0;
    $display("test suspend done");
  endtask
  task automatic t_power_off();
    wr_reg(`OFS_USB_INTERRUPT_FLAGS, 32'h0000_00FF);
    @(posedge clk);
    wr_reg(`OFS_USB_POWER_CONTROL, 32'h0000_0000);
    rd_reg(`OFS_USB_POWER_CONTROL, 8'h08);
    repeat (OFF_N + 4) @(posedge clk);
    rd_reg(`OFS_USB_POWER_CONTROL, 8'h00);
    outs(11'h004);
    pulse(5'h1F);
    rd_reg(`OFS_USB_INTERRUPT_FLAGS, 8'h00);
    // A write while the clock enable is low must not land
    ce <= 1'h0;
    wr_reg(`OFS_OTG_LINE_CONTROL, 32'h0000_00FF);
    @(posedge clk);
    ce <= 1'h1;
    rd_reg(`OFS_OTG_LINE_CONTROL, 8'h00);
    $display("test power off done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      $display("timeout after %0d cycles", cycles);
      summarize();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_reset();
    t_power_on();
    t_line();
    t_flags();
    t_suspend();
    t_power_off();
    summarize();
  end
endmodule
